/* hw/rre_regs.svh */
`ifndef RRE_REGS_SVH
`define RRE_REGS_SVH

`define RRE_GIE_BIT 3'd7
`define RRE_GIE_RESET 1'b0
`define RRE_CARRY_RESET 1'b0
`define RRE_DEST_ACC 1'b0
`define RRE_DEST_FILE 1'b1
`define RRE_RET_CYCLES 2
`define RRE_ROT_CYCLES 1
`define RRE_FILE_ADDR_MAX 7'h7F

`endif

/* hw/rre_pkg.sv */
package rre_pkg;

    typedef enum logic [2:0] {
        no_op,
        return_from_interrupt_op,
        return_with_literal_op,
        return_subroutine_op,
        rotate_left_carry_op
    } rre_op_t;

    typedef enum logic {
        st_idle,
        st_second
    } rre_state_t;

endpackage : rre_pkg

/* hw/rre_exec.sv */
`include "rre_regs.svh"

module rre_exec #(
    parameter int PC_WIDTH = 13
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic op_valid,
    input rre_pkg::rre_op_t op_code,
    input wire logic [7:0] literal,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [7:0] file_rdata,
    input wire logic [PC_WIDTH-1:0] stack_top,
    input wire logic irq_enable_clear,
    output logic busy,
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_WIDTH-1:0] pc_value,
    output logic acc_load,
    output logic [7:0] acc_value,
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic carry,
    output logic [7:0] interrupt_control_reg
);

    rre_pkg::rre_state_t state;
    logic accept;
    logic is_return;
    logic is_rotate;
    logic [7:0] rot_result;
    logic global_irq_enable;

    // an opcode presented while the second cycle of a return runs is ignored
    assign accept = op_valid && (state == rre_pkg::st_idle);
    assign is_return = (op_code == rre_pkg::return_from_interrupt_op) ||
                       (op_code == rre_pkg::return_with_literal_op) ||
                       (op_code == rre_pkg::return_subroutine_op);
    assign is_rotate = (op_code == rre_pkg::rotate_left_carry_op);
    assign rot_result = {file_rdata[6:0], carry};

    // returns spend a second cycle while fetch refills behind the new pc
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= rre_pkg::st_idle;
        end else begin
            case (state)
                rre_pkg::st_idle: begin
                    if (accept && is_return) begin
                        state <= rre_pkg::st_second;
                    end
                end
                rre_pkg::st_second: begin
                    state <= rre_pkg::st_idle;
                end
                default: begin
                    state <= rre_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy <= 1'b0;
        end else begin
            busy <= accept && is_return;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stack_pop <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= '0;
        end else begin
            stack_pop <= accept && is_return;
            pc_load <= accept && is_return;
            if (accept && is_return) begin
                pc_value <= stack_top;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_load <= 1'b0;
            acc_value <= 8'h00;
        end else begin
            acc_load <= 1'b0;
            if (accept && op_code == rre_pkg::return_with_literal_op) begin
                acc_load <= 1'b1;
                acc_value <= literal;
            end else if (accept && is_rotate && dest_sel == `RRE_DEST_ACC) begin
                acc_load <= 1'b1;
                acc_value <= rot_result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            file_we <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
        end else begin
            file_we <= accept && is_rotate && (dest_sel == `RRE_DEST_FILE);
            if (accept && is_rotate) begin
                file_waddr <= file_addr;
                file_wdata <= rot_result;
            end
        end
    end

    // carry is the only flag this block owns; returns never touch it
    always_ff @(posedge clk) begin
        if (reset) begin
            carry <= `RRE_CARRY_RESET;
        end else if (accept && is_rotate) begin
            carry <= file_rdata[7];
        end
    end

    // set wins over the interrupt-entry clear arriving in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            global_irq_enable <= `RRE_GIE_RESET;
        end else if (accept && op_code == rre_pkg::return_from_interrupt_op) begin
            global_irq_enable <= 1'b1;
        end else if (irq_enable_clear) begin
            global_irq_enable <= 1'b0;
        end
    end

    always_comb begin
        interrupt_control_reg = 8'h00;
        interrupt_control_reg[`RRE_GIE_BIT] = global_irq_enable;
    end

    property p_ret_pop;
        @(posedge clk) disable iff (reset)
        (accept && is_return) |=> (stack_pop && pc_load && pc_value == $past(stack_top));
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("return did not pop stack into pc");

    property p_gie_set;
        @(posedge clk) disable iff (reset)
        (accept && op_code == rre_pkg::return_from_interrupt_op) |=> interrupt_control_reg[7];
    endproperty
    a_gie_set: assert property (p_gie_set) else $error("interrupt enable not set by return");

    property p_ret_two_cycles;
        @(posedge clk) disable iff (reset)
        (accept && op_code == rre_pkg::return_from_interrupt_op) |=> busy ##1 (!busy && !stack_pop);
    endproperty
    a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("interrupt return not two cycles");

    property p_ret_flags_kept;
        @(posedge clk) disable iff (reset)
        (accept && is_return) |=> $stable(carry) ##1 $stable(carry);
    endproperty
    a_ret_flags_kept: assert property (p_ret_flags_kept) else $error("return changed carry");

    property p_literal;
        @(posedge clk) disable iff (reset)
        (accept && op_code == rre_pkg::return_with_literal_op) |=> (acc_load && acc_value == $past(literal));
    endproperty
    a_literal: assert property (p_literal) else $error("literal not loaded into accumulator");

    property p_literal_pc;
        @(posedge clk) disable iff (reset)
        (accept && op_code == rre_pkg::return_with_literal_op) |=> pc_load ##1 (!pc_load && !busy);
    endproperty
    a_literal_pc: assert property (p_literal_pc) else $error("literal return pc or timing wrong");

    property p_subret_no_acc;
        @(posedge clk) disable iff (reset)
        (accept && op_code == rre_pkg::return_subroutine_op) |=> (!acc_load && !file_we && busy);
    endproperty
    a_subret_no_acc: assert property (p_subret_no_acc) else $error("subroutine return wrote data");

    property p_carry_only_rot;
        @(posedge clk) disable iff (reset)
        !(accept && is_rotate) |=> $stable(carry);
    endproperty
    a_carry_only_rot: assert property (p_carry_only_rot) else $error("carry changed without rotate");

    property p_rot_dest;
        @(posedge clk) disable iff (reset)
        (accept && is_rotate) |=> (file_we == $past(dest_sel) && acc_load == !$past(dest_sel));
    endproperty
    a_rot_dest: assert property (p_rot_dest) else $error("rotate wrote wrong destination");

    property p_rot_single;
        @(posedge clk) disable iff (reset)
        (accept && is_rotate) |=> (!busy && !stack_pop && file_waddr == $past(file_addr));
    endproperty
    a_rot_single: assert property (p_rot_single) else $error("rotate not single cycle");

    property p_rot_value;
        @(posedge clk) disable iff (reset)
        (accept && is_rotate) |=> (carry == $past(file_rdata[7]) &&
            (($past(dest_sel) ? file_wdata : acc_value) == {$past(file_rdata[6:0]), $past(carry)}));
    endproperty
    a_rot_value: assert property (p_rot_value) else $error("rotate result or carry wrong");

    // no disable iff here: this one has to look at the edges where reset is high
    property p_reset_clear;
        @(posedge clk)
        reset |=> (!busy && !stack_pop && !pc_load && !acc_load && !file_we && !carry &&
            acc_value == 8'h00 && pc_value == '0 && interrupt_control_reg == 8'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear the block");

    property p_busy_ignore;
        @(posedge clk) disable iff (reset)
        busy |=> (!busy && !stack_pop && !pc_load && !acc_load && !file_we && $stable(carry));
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("opcode taken in second return cycle");

    property p_gie_clear;
        @(posedge clk) disable iff (reset)
        (irq_enable_clear && !(accept && op_code == rre_pkg::return_from_interrupt_op)) |=>
            !interrupt_control_reg[7];
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("interrupt enable not cleared");

    property p_subret_gie_kept;
        @(posedge clk) disable iff (reset)
        (accept && op_code == rre_pkg::return_subroutine_op && !irq_enable_clear) |=>
            $stable(interrupt_control_reg);
    endproperty
    a_subret_gie_kept: assert property (p_subret_gie_kept) else $error("subroutine return moved enable");

endmodule : rre_exec

/* verif/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 13;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic op_valid = 1'b0;
    rre_pkg::rre_op_t op_code = rre_pkg::no_op;
    logic [7:0] literal = 8'h00;
    logic [6:0] file_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [7:0] file_rdata = 8'h00;
    logic [PW-1:0] stack_top = '0;
    logic irq_enable_clear = 1'b0;
    logic busy, stack_pop, pc_load, acc_load, file_we, carry;
    logic [PW-1:0] pc_value;
    logic [7:0] acc_value, file_wdata, interrupt_control_reg;
    logic [6:0] file_waddr;
    int fails = 0;
    int checked = 0;
    int seed;
    logic m_carry = 1'b0;
    logic m_gie = 1'b0;
    logic [7:0] m_acc = 8'h00;
    logic [PW-1:0] m_pc = '0;

    always #5 clk = ~clk;

    rre_exec #(.PC_WIDTH(PW)) uut (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
        .literal(literal), .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata),
        .stack_top(stack_top), .irq_enable_clear(irq_enable_clear), .busy(busy), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .acc_load(acc_load), .acc_value(acc_value),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .carry(carry),
        .interrupt_control_reg(interrupt_control_reg));

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkv

    function automatic logic [7:0] rot(input logic [7:0] v, input logic c);
        return {v[6:0], c};
    endfunction : rot

    task automatic check_state;
        chk1(carry, m_carry);
        chkv(16'(acc_value), 16'(m_acc));
        chkv(16'(pc_value), 16'(m_pc));
        chkv(16'(interrupt_control_reg), {8'h00, m_gie, 7'h00});
    endtask : check_state

    task automatic run_op(input rre_pkg::rre_op_t op, input logic [7:0] lit, input logic [7:0] rd,
                          input logic [6:0] fa, input logic ds, input logic clr);
        logic ret;
        logic rl;
        logic [7:0] r;
        logic [PW-1:0] st;
        ret = op inside {rre_pkg::return_from_interrupt_op, rre_pkg::return_with_literal_op,
                         rre_pkg::return_subroutine_op};
        rl = op == rre_pkg::rotate_left_carry_op;
        r = rot(rd, m_carry);
        st = PW'($urandom);
        op_valid = 1'b1;
        op_code = op;
        literal = lit;
        file_rdata = rd;
        file_addr = fa;
        dest_sel = ds;
        stack_top = st;
        irq_enable_clear = clr;
        @(negedge clk);
        if (ret) m_pc = st;
        if (op == rre_pkg::return_from_interrupt_op) m_gie = 1'b1;
        else if (clr) m_gie = 1'b0;
        if (op == rre_pkg::return_with_literal_op) m_acc = lit;
        if (rl) m_carry = rd[7];
        if (rl && !ds) m_acc = r;
        chk1(stack_pop, ret);
        chk1(pc_load, ret);
        chk1(busy, ret);
        chk1(acc_load, op == rre_pkg::return_with_literal_op || (rl && !ds));
        chk1(file_we, rl && ds);
        if (rl && ds) begin
            chkv(16'(file_waddr), 16'(fa));
            chkv(16'(file_wdata), 16'(r));
        end
        check_state();
        if (ret) begin
            // second cycle of a return: this rotate must be ignored
            op_code = rre_pkg::rotate_left_carry_op;
            dest_sel = 1'b1;
            irq_enable_clear = 1'b0;
            @(negedge clk);
            chkv(16'({busy, stack_pop, pc_load, acc_load, file_we}), 16'h0000);
            check_state();
        end
    endtask : run_op

    task automatic tally_and_finish;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end

    initial begin
        seed = $urandom(31);
        repeat (20) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chkv(16'({busy, stack_pop, pc_load, acc_load, file_we}), 16'h0000);
        check_state();
        run_op(rre_pkg::return_from_interrupt_op, 8'h00, 8'h00, 7'h00, 1'b0, 1'b1);
        run_op(rre_pkg::rotate_left_carry_op, 8'h00, 8'hE6, 7'h7F, 1'b0, 1'b0);
        run_op(rre_pkg::rotate_left_carry_op, 8'h00, 8'h80, 7'h00, 1'b1, 1'b0);
        run_op(rre_pkg::return_with_literal_op, 8'hFF, 8'h00, 7'h00, 1'b0, 1'b0);
        run_op(rre_pkg::no_op, 8'h00, 8'h00, 7'h00, 1'b0, 1'b1);
        run_op(rre_pkg::return_subroutine_op, 8'h00, 8'h00, 7'h00, 1'b0, 1'b0);
        run_op(rre_pkg::return_with_literal_op, 8'h00, 8'h00, 7'h00, 1'b0, 1'b0);
        $display("corner test done");
        // reset in mid-run while carry, interrupt enable and pc hold non-zero values
        run_op(rre_pkg::return_from_interrupt_op, 8'h00, 8'h00, 7'h00, 1'b0, 1'b0);
        reset = 1'b1;
        op_valid = 1'b0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        m_carry = 1'b0;
        m_gie = 1'b0;
        m_acc = 8'h00;
        m_pc = '0;
        @(negedge clk);
        chkv(16'({busy, stack_pop, pc_load, acc_load, file_we}), 16'h0000);
        check_state();
        $display("reset test done");
        for (int i = 0; i < 300; i++) begin
            run_op(rre_pkg::rre_op_t'(3'($urandom_range(4, 0))), 8'($urandom), 8'($urandom),
                   7'($urandom), 1'($urandom), ($urandom_range(3, 0) == 0));
        end
        op_valid = 1'b0;
        irq_enable_clear = 1'b0;
        $display("random test done");
        tally_and_finish();
    end
endmodule : tb_top
